/* hdl/vpc_pkg.sv */
// register map, field layout and reset values of the video preamp control bank
package vpc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 4;
  localparam int CHAR_ADDR_W = 9;
  localparam int BANK_W = 3;
  localparam int POS_W = 4;

  typedef logic [ADDR_W-1:0] vpc_addr_t;
  typedef logic [DATA_W-1:0] vpc_data_t;

  // register offsets
  localparam vpc_addr_t DAC_CONFIG_OFFS = 16'h8438;
  localparam vpc_addr_t GLOBAL_CTRL_OFFS = 16'h8439;
  localparam vpc_addr_t AUX_CTRL_OFFS = 16'h843a;
  localparam vpc_addr_t LOOP_RANGE_OFFS = 16'h843e;

  // register indices inside the bank
  typedef enum logic [1:0] {
    VPC_IDX_DAC_CONFIG = 2'b00,
    VPC_IDX_GLOBAL = 2'b01,
    VPC_IDX_AUX = 2'b10,
    VPC_IDX_LOOP = 2'b11
  } vpc_reg_idx_t;

  // reset values
  localparam vpc_data_t DAC_CONFIG_RST = 8'h00;
  localparam vpc_data_t GLOBAL_CTRL_RST = 8'h00;
  localparam vpc_data_t AUX_CTRL_RST = 8'h00;
  localparam vpc_data_t LOOP_RANGE_RST = 8'h00;

  // dac config fields
  localparam int DC_OFFSET_LSB = 0;
  localparam int DC_OFFSET_W = 3;
  localparam int OVL_CONTRAST_LSB = 3;
  localparam int OVL_CONTRAST_W = 2;
  localparam int DAC_RANGE_BIT = 5;
  localparam int DAC4_MIX_BIT = 6;

  // global control fields
  localparam int BLANK_VIDEO_BIT = 0;
  localparam int POWER_SAVE_BIT = 1;
  localparam int BANK_SEL_DIS_BIT = 2;

  // auxiliary control fields
  localparam int HBLANK_DIS_BIT = 0;
  localparam int HBLANK_POS_EN_BIT = 2;
  localparam int HBLANK_POS_LSB = 3;

  // loop range fields
  localparam int LOOP_PRECAL_LSB = 0;
  localparam int LOOP_PRECAL_W = 2;
  localparam int VBLANK_GATE_BIT = 2;
  localparam int OVERRIDE_BIT = 3;
  localparam int CLAMP_POL_BIT = 5;
  localparam int LOOP_AUTO_BIT = 6;

  // bank select register layout and character address split
  localparam int BANK_LO_LSB = 0;
  localparam int BANK_HI_LSB = 4;
  localparam int CHAR_LOW_W = 6;
  localparam int CHAR_SEL_LSB = 6;

  // read answer for an unmapped offset
  localparam vpc_data_t UNMAPPED_RDATA = 8'h00;

endpackage : vpc_pkg

/* hdl/vpc_hblank_shaper.sv */
// horizontal blanking pulse, fixed or shifted by a programmable pixel count
module vpc_hblank_shaper
  import vpc_pkg::*;
#(
  parameter int MAX_SHIFT = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic hblank_in,
  input wire logic pixel_tick_in,
  input wire logic position_enable_in,
  input wire logic [POS_W-1:0] position_in,
  output logic hblank_out
);

  logic [MAX_SHIFT-1:0] delay_reg;
  logic [MAX_SHIFT-1:0] delay_next;
  logic hblank_reg;
  logic hblank_next;
  logic delayed_w;

  // history of the blanking input, one stage per pixel
  assign delay_next = pixel_tick_in ? {delay_reg[MAX_SHIFT-2:0], hblank_in} : delay_reg;
  // zero position means no shift even when programmable
  assign delayed_w = (position_in == '0) ? hblank_in : delay_reg[position_in - 1'b1];
  assign hblank_next = position_enable_in ? delayed_w : hblank_in;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      delay_reg <= '0;
      hblank_reg <= 1'b0;
    end else begin
      delay_reg <= delay_next;
      hblank_reg <= hblank_next;
    end
  end

  assign hblank_out = hblank_reg;

endmodule : vpc_hblank_shaper

/* hdl/vpc_rom_addr_map.sv */
// page ram character address to rom character address
module vpc_rom_addr_map
  import vpc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic bank_select_disable_in,
  input wire logic [CHAR_ADDR_W-1:0] page_char_addr_in,
  input wire logic [DATA_W-1:0] bank_sel_a_in,
  input wire logic [DATA_W-1:0] bank_sel_b_in,
  output logic [CHAR_ADDR_W-1:0] rom_char_addr_out
);

  logic [BANK_W-1:0] bank_w;
  logic [1:0] sel_w;
  logic [CHAR_ADDR_W-1:0] banked_w;
  logic [CHAR_ADDR_W-1:0] addr_next;
  logic [CHAR_ADDR_W-1:0] addr_reg;

  assign sel_w = page_char_addr_in[CHAR_SEL_LSB +: 2];
  // page bits seven and six pick one of four bank fields
  assign bank_w = (sel_w == 2'b00) ? bank_sel_a_in[BANK_LO_LSB +: BANK_W] :
                  (sel_w == 2'b01) ? bank_sel_a_in[BANK_HI_LSB +: BANK_W] :
                  (sel_w == 2'b10) ? bank_sel_b_in[BANK_LO_LSB +: BANK_W] :
                  bank_sel_b_in[BANK_HI_LSB +: BANK_W];
  assign banked_w = {bank_w, page_char_addr_in[CHAR_LOW_W-1:0]};
  assign addr_next = bank_select_disable_in ? page_char_addr_in : banked_w;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  assign rom_char_addr_out = addr_reg;

endmodule : vpc_rom_addr_map

/* hdl/vpc_control_regs.sv */
// control register bank of the video preamplifier and the signals it steers
//
// Overview of operation
// - three low dac config bits set the dc offset of all colour outputs.
// - dac config bits four and three set overlay character contrast.
// - dac config bit five picks the low full-scale range of dacs one to three.
// - dac config bit six halves dac four and mixes it into dacs one to three.
// - global bit zero forces every video output to black level.
// - global bit one shuts the analogue sections down for low power.
// - global bit two resets low for bank select; one gives full 512-character addressing.
// - aux bit zero low gates external horizontal blanking; high suppresses it.
// - aux bit two resets low for fixed blank position; high uses programmable position.
// - aux bits six to three shift the horizontal blank by that many pixels.
// - loop range bit two gates vertical blanking onto the video outputs.
// - loop range bit three replaces incoming video with overlay characters only.
// - loop range bit five selects a negative-going rather than positive clamp pulse.
// - loop range bit six lets the loop choose its own frequency range.
// - bank mode rom address is selected bank field joined to six low page bits.
module vpc_control_regs
  import vpc_pkg::*;
#(
  parameter int HBLANK_MAX_SHIFT = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port from the serial bus front end
  input wire vpc_pkg::vpc_addr_t reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire vpc_pkg::vpc_data_t reg_wdata_in,
  input wire logic reg_rd_en_in,
  output vpc_pkg::vpc_data_t reg_rdata_out,
  output logic reg_rd_valid_out,
  output logic reg_hit_out,
  // timing inputs from deflection and overlay logic
  input wire logic hblank_in,
  input wire logic vblank_in,
  input wire logic pixel_tick_in,
  input wire logic clamp_pulse_in,
  input wire logic [vpc_pkg::CHAR_ADDR_W-1:0] page_char_addr_in,
  input wire vpc_pkg::vpc_data_t bank_sel_a_in,
  input wire vpc_pkg::vpc_data_t bank_sel_b_in,
  // settings to the analogue sections
  output logic [vpc_pkg::DC_OFFSET_W-1:0] dc_offset_out,
  output logic [vpc_pkg::OVL_CONTRAST_W-1:0] overlay_contrast_out,
  output logic dac_range_low_out,
  output logic dac4_mix_out,
  output logic blank_video_out,
  output logic power_save_out,
  output logic bank_select_disable_out,
  output logic hblank_disable_out,
  output logic hblank_position_enable_out,
  output logic [vpc_pkg::POS_W-1:0] hblank_position_out,
  output logic vertical_blank_gate_out,
  output logic overlay_override_out,
  output logic clamp_polarity_out,
  output logic loop_auto_range_out,
  output logic [vpc_pkg::LOOP_PRECAL_W-1:0] loop_precal_bits_out,
  // derived video controls
  output logic video_black_out,
  output logic video_pass_out,
  output logic clamp_active_out,
  output logic [vpc_pkg::CHAR_ADDR_W-1:0] rom_char_addr_out
);

  import vpc_pkg::*;

  // register storage, one word per register
  vpc_data_t regs_reg [NUM_REGS];
  // reset words per index, constants so the async reset branch stays clean
  localparam vpc_data_t REG_RST [NUM_REGS] = '{DAC_CONFIG_RST, GLOBAL_CTRL_RST, AUX_CTRL_RST, LOOP_RANGE_RST};
  logic [NUM_REGS-1:0] sel_w;
  logic [NUM_REGS-1:0] wr_w;
  logic hit_w;
  vpc_data_t rd_mux_w;
  vpc_data_t rdata_reg;
  vpc_data_t rdata_next;
  logic rd_valid_reg;

  // address decode
  assign sel_w[VPC_IDX_DAC_CONFIG] = (reg_addr_in == DAC_CONFIG_OFFS);
  assign sel_w[VPC_IDX_GLOBAL] = (reg_addr_in == GLOBAL_CTRL_OFFS);
  assign sel_w[VPC_IDX_AUX] = (reg_addr_in == AUX_CTRL_OFFS);
  assign sel_w[VPC_IDX_LOOP] = (reg_addr_in == LOOP_RANGE_OFFS);
  assign hit_w = |sel_w;
  assign reg_hit_out = hit_w;

  // whole byte stored, reserved bits included, so a read shows the exact write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign wr_w[gi] = reg_wr_en_in && sel_w[gi];
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          regs_reg[gi] <= REG_RST[gi];
        end else if (wr_w[gi]) begin
          regs_reg[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // read path
  assign rd_mux_w = sel_w[VPC_IDX_DAC_CONFIG] ? regs_reg[VPC_IDX_DAC_CONFIG] :
                    sel_w[VPC_IDX_GLOBAL] ? regs_reg[VPC_IDX_GLOBAL] :
                    sel_w[VPC_IDX_AUX] ? regs_reg[VPC_IDX_AUX] :
                    sel_w[VPC_IDX_LOOP] ? regs_reg[VPC_IDX_LOOP] :
                    UNMAPPED_RDATA;
  assign rdata_next = reg_rd_en_in ? rd_mux_w : rdata_reg;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= UNMAPPED_RDATA;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= reg_rd_en_in;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rd_valid_out = rd_valid_reg;

  // field outputs straight from the register flops
  vpc_data_t dac_cfg_w;
  vpc_data_t glob_w;
  vpc_data_t aux_w;
  vpc_data_t loop_w;

  assign dac_cfg_w = regs_reg[VPC_IDX_DAC_CONFIG];
  assign glob_w = regs_reg[VPC_IDX_GLOBAL];
  assign aux_w = regs_reg[VPC_IDX_AUX];
  assign loop_w = regs_reg[VPC_IDX_LOOP];

  assign dc_offset_out = dac_cfg_w[DC_OFFSET_LSB +: DC_OFFSET_W];
  assign overlay_contrast_out = dac_cfg_w[OVL_CONTRAST_LSB +: OVL_CONTRAST_W];
  assign dac_range_low_out = dac_cfg_w[DAC_RANGE_BIT];
  assign dac4_mix_out = dac_cfg_w[DAC4_MIX_BIT];
  assign blank_video_out = glob_w[BLANK_VIDEO_BIT];
  assign power_save_out = glob_w[POWER_SAVE_BIT];
  assign bank_select_disable_out = glob_w[BANK_SEL_DIS_BIT];
  assign hblank_disable_out = aux_w[HBLANK_DIS_BIT];
  assign hblank_position_enable_out = aux_w[HBLANK_POS_EN_BIT];
  assign hblank_position_out = aux_w[HBLANK_POS_LSB +: POS_W];
  // passed out untouched; pre-calibration relies on the host writing zero here
  assign loop_precal_bits_out = loop_w[LOOP_PRECAL_LSB +: LOOP_PRECAL_W];
  assign vertical_blank_gate_out = loop_w[VBLANK_GATE_BIT];
  assign overlay_override_out = loop_w[OVERRIDE_BIT];
  assign clamp_polarity_out = loop_w[CLAMP_POL_BIT];
  assign loop_auto_range_out = loop_w[LOOP_AUTO_BIT];

  // horizontal blanking shaping
  logic hblank_shaped_w;

  vpc_hblank_shaper #(
    .MAX_SHIFT(HBLANK_MAX_SHIFT)
  ) u_hblank (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .hblank_in(hblank_in),
    .pixel_tick_in(pixel_tick_in),
    .position_enable_in(aux_w[HBLANK_POS_EN_BIT]),
    .position_in(aux_w[HBLANK_POS_LSB +: POS_W]),
    .hblank_out(hblank_shaped_w)
  );

  // composite black and video pass, registered so outputs are glitch free
  logic hgate_w;
  logic vgate_w;
  logic black_next;
  logic pass_next;
  logic clamp_next;
  logic black_reg;
  logic pass_reg;
  logic clamp_reg;

  assign hgate_w = hblank_shaped_w && !aux_w[HBLANK_DIS_BIT];
  assign vgate_w = vblank_in && loop_w[VBLANK_GATE_BIT];
  assign black_next = glob_w[BLANK_VIDEO_BIT] || hgate_w || vgate_w;
  assign pass_next = !loop_w[OVERRIDE_BIT] && !glob_w[POWER_SAVE_BIT];
  // clamp is active high inside; an inverted pulse is flipped back here
  assign clamp_next = clamp_pulse_in ^ loop_w[CLAMP_POL_BIT];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      black_reg <= 1'b0;
      pass_reg <= 1'b0;
      clamp_reg <= 1'b0;
    end else begin
      black_reg <= black_next;
      pass_reg <= pass_next;
      clamp_reg <= clamp_next;
    end
  end

  assign video_black_out = black_reg;
  assign video_pass_out = pass_reg;
  assign clamp_active_out = clamp_reg;

  // character rom address
  vpc_rom_addr_map u_rom_map (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .bank_select_disable_in(glob_w[BANK_SEL_DIS_BIT]),
    .page_char_addr_in(page_char_addr_in),
    .bank_sel_a_in(bank_sel_a_in),
    .bank_sel_b_in(bank_sel_b_in),
    .rom_char_addr_out(rom_char_addr_out)
  );

endmodule : vpc_control_regs

/* tb/vpc_host_model.sv */
// register port master standing in for the serial bus front end
module vpc_host_model
  import vpc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire vpc_pkg::vpc_data_t rdata_in,
  input wire logic valid_in,
  output vpc_pkg::vpc_addr_t addr_out,
  output logic wr_out,
  output vpc_pkg::vpc_data_t wdata_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = '0;
    wr_out = 1'b0;
    wdata_out = '0;
    rd_out = 1'b0;
  end
  // reserved places of the four registers go out as zero while wr_out is high
  function automatic vpc_data_t keep_mask(input vpc_addr_t a);
    case (a)
      DAC_CONFIG_OFFS: keep_mask = 8'h7f;
      GLOBAL_CTRL_OFFS: keep_mask = 8'h07;
      AUX_CTRL_OFFS: keep_mask = 8'h7d;
      LOOP_RANGE_OFFS: keep_mask = 8'h6c;
      default: keep_mask = 8'hff;
    endcase
  endfunction : keep_mask
  task automatic wr(input vpc_addr_t a, input vpc_data_t d);
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = d & keep_mask(a);
    wr_out = 1'b1;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    // released data must not look like the last byte
    wdata_out = ~wdata_out;
  endtask : wr
  task automatic rd(input vpc_addr_t a, output vpc_data_t d);
    @(negedge sys_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
    d = valid_in ? rdata_in : 8'hxx;
  endtask : rd
endmodule : vpc_host_model

/* tb/vpc_control_regs_assertions.sv */
// port assertions of the control register bank
module vpc_control_regs_assertions
  import vpc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rd_valid_out,
  input wire logic vblank_in,
  input wire logic clamp_pulse_in,
  input wire logic [8:0] page_char_addr_in,
  input wire logic [7:0] bank_sel_a_in,
  input wire logic [7:0] bank_sel_b_in,
  input wire logic [2:0] dc_offset_out,
  input wire logic [1:0] overlay_contrast_out,
  input wire logic dac_range_low_out,
  input wire logic dac4_mix_out,
  input wire logic blank_video_out,
  input wire logic power_save_out,
  input wire logic bank_select_disable_out,
  input wire logic hblank_disable_out,
  input wire logic hblank_position_enable_out,
  input wire logic [3:0] hblank_position_out,
  input wire logic vertical_blank_gate_out,
  input wire logic overlay_override_out,
  input wire logic clamp_polarity_out,
  input wire logic loop_auto_range_out,
  input wire logic video_black_out,
  input wire logic clamp_active_out,
  input wire logic [8:0] rom_char_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wr_dac = reg_wr_en_in && reg_addr_in == DAC_CONFIG_OFFS;
  wire wr_glb = reg_wr_en_in && reg_addr_in == GLOBAL_CTRL_OFFS;
  wire wr_aux = reg_wr_en_in && reg_addr_in == AUX_CTRL_OFFS;
  wire wr_loop = reg_wr_en_in && reg_addr_in == LOOP_RANGE_OFFS;
  wire rd_dac = reg_rd_en_in && reg_addr_in == DAC_CONFIG_OFFS;
  wire [6:0] dac_w = {dac4_mix_out, dac_range_low_out, overlay_contrast_out, dc_offset_out};
  wire [2:0] bank_a = page_char_addr_in[6] ? bank_sel_a_in[6:4] : bank_sel_a_in[2:0];
  wire [2:0] bank_b = page_char_addr_in[6] ? bank_sel_b_in[6:4] : bank_sel_b_in[2:0];
  wire [2:0] bank_w = page_char_addr_in[7] ? bank_b : bank_a;
  wire [8:0] rom_w = bank_select_disable_out ? page_char_addr_in : {bank_w, page_char_addr_in[5:0]};
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  dac_fields_a: assert property (wr_dac |=> dac_w == $past(reg_wdata_in[6:0]))
    else $error("dac config fields wrong");
  global_fields_a: assert property (wr_glb |=>
    {bank_select_disable_out, power_save_out, blank_video_out} == $past(reg_wdata_in[2:0]))
    else $error("global fields wrong");
  aux_fields_a: assert property (wr_aux |=> {hblank_position_out, hblank_position_enable_out,
    hblank_disable_out} == {$past(reg_wdata_in[6:2]), $past(reg_wdata_in[0])})
    else $error("aux fields wrong");
  loop_fields_a: assert property (wr_loop |=> {loop_auto_range_out, clamp_polarity_out,
    overlay_override_out, vertical_blank_gate_out} == {$past(reg_wdata_in[6:5]), $past(reg_wdata_in[3:2])})
    else $error("loop fields wrong");
  read_back_a: assert property (rd_dac |=> reg_rd_valid_out && reg_rdata_out[6:0] == $past(dac_w))
    else $error("dac config read back wrong");
  vblank_gate_a: assert property (vblank_in && vertical_blank_gate_out |=> video_black_out)
    else $error("vertical blank not gated");
  clamp_pol_a: assert property (clamp_active_out == $past(clamp_pulse_in ^ clamp_polarity_out))
    else $error("clamp polarity wrong");
  rom_addr_a: assert property (rom_char_addr_out == $past(rom_w))
    else $error("rom address wrong");
  cover property (rd_dac);
  cover property (vblank_in && vertical_blank_gate_out);
  cover property (!bank_select_disable_out && page_char_addr_in[7]);
endmodule : vpc_control_regs_assertions
bind vpc_control_regs vpc_control_regs_assertions u_chk (.*);

/* tb/vpc_control_regs_tb.sv */
// self-checking bench of the control register bank
module vpc_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vpc_pkg::*;
  logic sys_clk_in = 0, reset_n_in = 0, hblank_in = 0, vblank_in = 0, pixel_tick_in = 0, clamp_pulse_in = 0;
  logic [8:0] page_char_addr_in = '0, rom_char_addr_out;
  vpc_data_t bank_sel_a_in = '0, bank_sel_b_in = '0, reg_wdata_in, reg_rdata_out, d;
  vpc_addr_t reg_addr_in;
  logic reg_wr_en_in, reg_rd_en_in, reg_rd_valid_out, reg_hit_out, dac_range_low_out, dac4_mix_out;
  logic blank_video_out, power_save_out, bank_select_disable_out, hblank_disable_out, hblank_position_enable_out;
  logic vertical_blank_gate_out, overlay_override_out, clamp_polarity_out, loop_auto_range_out;
  logic video_black_out, video_pass_out, clamp_active_out;
  logic [2:0] dc_offset_out;
  logic [1:0] overlay_contrast_out, loop_precal_bits_out;
  logic [3:0] hblank_position_out;
  int miscompares = 0, n_tests = 0, k;
  always #2 sys_clk_in = ~sys_clk_in;
  vpc_control_regs u_dut (.*);
  vpc_host_model u_host (.sys_clk_in(sys_clk_in), .rdata_in(reg_rdata_out), .valid_in(reg_rd_valid_out),
    .addr_out(reg_addr_in), .wr_out(reg_wr_en_in), .wdata_out(reg_wdata_in), .rd_out(reg_rd_en_in));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // bounded wait for the blanking output after a one-cycle hblank pulse
  task automatic pulse_lat(output int n);
    hblank_in = 1;
    @(negedge sys_clk_in);
    hblank_in = 0;
    n = 1;
    while (video_black_out !== 1'b1 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    repeat (30) @(negedge sys_clk_in);
  endtask : pulse_lat
  task automatic t_reset();
    vpc_addr_t offs [4] = '{DAC_CONFIG_OFFS, GLOBAL_CTRL_OFFS, AUX_CTRL_OFFS, LOOP_RANGE_OFFS};
    foreach (offs[i]) begin
      u_host.rd(offs[i], d);
      check(d, 8'h00);
    end
    check({bank_select_disable_out, hblank_position_enable_out, video_pass_out}, 3'b001);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_dac();
    vpc_data_t pat [3] = '{8'h7f, 8'h2a, 8'h55};
    foreach (pat[i]) begin
      u_host.wr(DAC_CONFIG_OFFS, pat[i]);
      check({dac4_mix_out, dac_range_low_out, overlay_contrast_out, dc_offset_out}, pat[i][6:0]);
      u_host.rd(DAC_CONFIG_OFFS, d);
      check(d, pat[i]);
    end
    $display("t_dac done");
  endtask : t_dac
  task automatic t_global();
    for (int i = 0; i < 3; i++) begin
      u_host.wr(GLOBAL_CTRL_OFFS, 8'h01 << i);
      @(negedge sys_clk_in);
      check({bank_select_disable_out, power_save_out, blank_video_out}, 3'b001 << i);
      check({video_black_out, video_pass_out}, {i == 0, i != 1});
    end
    $display("t_global done");
  endtask : t_global
  task automatic t_hblank();
    u_host.wr(GLOBAL_CTRL_OFFS, 8'h00);
    pulse_lat(k);
    check(k, 2);
    u_host.wr(AUX_CTRL_OFFS, 8'h1c);
    pixel_tick_in = 1;
    pulse_lat(k);
    check({hblank_position_out, k[7:0]}, {4'h3, 8'd5});
    // programmable with position zero behaves like the fixed position
    u_host.wr(AUX_CTRL_OFFS, 8'h04);
    pulse_lat(k);
    check(k, 2);
    u_host.wr(AUX_CTRL_OFFS, 8'h01);
    pulse_lat(k);
    check(k, 40);
    pixel_tick_in = 0;
    $display("t_hblank done");
  endtask : t_hblank
  task automatic t_loop();
    u_host.wr(LOOP_RANGE_OFFS, 8'h67);
    check({loop_auto_range_out, clamp_polarity_out, overlay_override_out, vertical_blank_gate_out}, 4'hd);
    check(loop_precal_bits_out, 2'b00);
    vblank_in = 1;
    @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    check({video_black_out, clamp_active_out}, 2'b11);
    vblank_in = 0;
    clamp_pulse_in = 1;
    u_host.wr(LOOP_RANGE_OFFS, 8'h08);
    @(negedge sys_clk_in);
    check({video_black_out, video_pass_out, clamp_active_out, loop_auto_range_out}, 4'h2);
    $display("t_loop done");
  endtask : t_loop
  task automatic t_rom();
    logic [2:0] fld [4] = '{3'd1, 3'd5, 3'd3, 3'd7};
    bank_sel_a_in = 8'h51;
    bank_sel_b_in = 8'h73;
    for (int u = 0; u < 4; u++) begin
      page_char_addr_in = {1'b0, u[1:0], 6'h2a};
      @(negedge sys_clk_in);
      check(rom_char_addr_out, {fld[u], 6'h2a});
    end
    u_host.wr(GLOBAL_CTRL_OFFS, 8'h04);
    page_char_addr_in = 9'h1ab;
    @(negedge sys_clk_in);
    check(rom_char_addr_out, 9'h1ab);
    $display("t_rom done");
  endtask : t_rom
  task automatic t_unmapped();
    u_host.wr(16'h843b, 8'hff);
    u_host.rd(16'h843b, d);
    check({reg_hit_out, d}, 9'h000);
    u_host.rd(GLOBAL_CTRL_OFFS, d);
    check({reg_hit_out, d}, 9'h104);
    $display("t_unmapped done");
  endtask : t_unmapped
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_n_in = 1;
    t_reset();
    t_dac();
    t_global();
    t_hblank();
    t_loop();
    t_rom();
    t_unmapped();
    close_out();
  end
endmodule : vpc_control_regs_tb
